// [ueb_pkg.sv]
// Package: register map, field positions, timing and carrier types for the USB endpoint block
package ueb_pkg;

   // ==========================================================================
   // Register offsets (byte addresses, one 32-bit word each)
   localparam logic [7:0] OFS_OUT_EN   = 8'h00;
   localparam logic [7:0] OFS_IN_EN    = 8'h04;
   localparam logic [7:0] OFS_SIZE_LO  = 8'h08;
   localparam logic [7:0] OFS_SIZE_HI  = 8'h0c;
   localparam logic [7:0] OFS_DEPTH    = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [7:0] OFS_CLKCTL   = 8'h18;
   localparam logic [7:0] OFS_ACCESS   = 8'h1c;
   localparam logic [7:0] OFS_EP_IE    = 8'h20;
   localparam logic [7:0] OFS_INTCTL   = 8'h24;
   // Data ports 0x40..0x5c, endpoint number in address bits 4:2
   localparam logic [2:0] DATA_PAGE    = 3'h2;

   // ==========================================================================
   // Field positions and masks
   localparam int         BIT_TOGGLE   = 0;
   localparam int         BIT_BUS_IDLE_SLEEP_FLAG     = 0;
   localparam int         BIT_RESUME   = 1;
   localparam int         BIT_REMOTE_WAKE_REQUEST     = 2;
   localparam int         BIT_CLKEN    = 0;
   localparam int         BIT_DEEP     = 1;
   localparam int         BIT_GIE      = 0;
   localparam int         BIT_USBE     = 1;
   localparam int         BIT_USBF     = 2;
   localparam int         BIT_E2DB     = 0;
   localparam int         BIT_E3DB     = 2;
   localparam logic [7:0] OUT_EN_EPS   = 8'hf2;
   localparam logic [7:0] SIZE_LO_MASK = 8'hfc;
   localparam logic [7:0] DEPTH_MASK   = 8'h0f;
   localparam logic [7:0] RST_REG8     = 8'h00;
   localparam logic [7:0] BASE_BYTES   = 8'h08;

   // ==========================================================================
   // Timing
   localparam int         CLK_HZ       = 50_000_000;
   localparam int         IDLE_BUS_IDLE_SLEEP_FLAG_US = 3000;
   localparam int         RWAKE_US     = 1000;
   localparam int         IDLE_BUS_IDLE_SLEEP_FLAG_CYC = IDLE_BUS_IDLE_SLEEP_FLAG_US * (CLK_HZ / 1_000_000);
   localparam int         RWAKE_CYC    = RWAKE_US * (CLK_HZ / 1_000_000);
   localparam int         CNT_W        = 20;

   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } ueb_avs_req_s;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       pkt_done;
      logic [2:0] ep;
      logic [7:0] wdata;
   } ueb_sie_req_s;

   typedef struct packed {
      logic [7:0]       out_en;
      logic [7:0]       in_en;
      logic [7:0]       size_lo;
      logic [7:0]       size_hi;
      logic [7:0]       acc_flag;
      logic [7:0]       ep_ie;
      logic [7:0]       toggle;
      logic [7:0]       ep_en_q;
      logic             bus_idle_sleep_flag;
      logic             resume;
      logic             remote_wake_request;
      logic             clk_en;
      logic             deep;
      logic             gie;
      logic             usbe;
      logic             usbf;
      logic             evt;
      logic             sync1;
      logic             sync2;
      logic             done;
      logic [CNT_W-1:0] idle_cnt;
      logic [CNT_W-1:0] wake_cnt;
      logic [31:0]      rdata;
      logic [7:0]       sie_rdata;
      logic [7:0][6:0]  fw_ptr;
      logic [7:0][6:0]  sie_ptr;
   } ueb_state_s;

endpackage : ueb_pkg

// [ueb_endpoint.sv]
// Endpoint buffers, suspend/resume/wake-up and USB interrupt source with Avalon-MM registers
`timescale 1ns/1ps

module ueb_endpoint
   import ueb_pkg::*;
#(
   parameter logic [19:0] IDLE_CYC  = 20'(ueb_pkg::IDLE_BUS_IDLE_SLEEP_FLAG_CYC),
   parameter logic [19:0] RWAKE_LEN = 20'(ueb_pkg::RWAKE_CYC)
)(
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  por_n,
   input  wire logic                  ce,
   input  wire ueb_pkg::ueb_avs_req_s avs,
   output logic                       avs_waitrequest,
   output logic [31:0]                avs_readdata,
   input  wire logic                  line_active,
   input  wire logic                  host_resume,
   input  wire logic                  bus_reset_det,
   input  wire ueb_pkg::ueb_sie_req_s sie,
   output logic [7:0]                 sie_rdata,
   output logic [7:0]                 ep_buf_enable,
   output logic [7:0]                 ep_toggle,
   output logic                       link_clk_en,
   output logic                       deep_low_power,
   output logic                       remote_wake_drive,
   output logic                       usb_irq
);
   import ueb_pkg::*;

   // ==========================================================================
   // State
   ueb_state_s      st;
   ueb_state_s      next_st;
   logic [7:0]      depth;
   logic [7:0]      mem [0:1023];
   logic [7:0]      ep_en;
   logic [7:0][6:0] cap_mask;
   logic            req;
   logic            take;
   logic            lane0;
   logic            dp_hit;
   logic [2:0]      dp_ep;
   logic [9:0]      fw_idx;
   logic [9:0]      sie_idx;
   logic            fw_we;
   logic            sie_ok;
   logic            sie_we;

   // ==========================================================================
   // Per-endpoint enable and buffer capacity
   generate
      for (genvar i = 0; i < 8; i++)
      begin : g_ep
         logic [1:0] sz;
         logic       dbl;
         logic [7:0] cap;
         if (i == 0)
         begin : g_ep0
            // Control endpoint is always on and fixed at the base size
            assign sz       = 2'b00;
            assign ep_en[i] = 1'b1;
         end
         else if (i < 4)
         begin : g_lo
            assign sz       = st.size_lo[2*i+1 -: 2];
            assign ep_en[i] = st.in_en[i] | (OUT_EN_EPS[i] & st.out_en[i]);
         end
         else
         begin : g_hi
            assign sz       = st.size_hi[2*(i-4)+1 -: 2];
            assign ep_en[i] = st.in_en[i] | (OUT_EN_EPS[i] & st.out_en[i]);
         end
         if (i == 2)
         begin : g_db2
            assign dbl = depth[BIT_E2DB];
         end
         else if (i == 3)
         begin : g_db3
            assign dbl = depth[BIT_E3DB];
         end
         else
         begin : g_sb
            assign dbl = 1'b0;
         end
         assign cap         = (BASE_BYTES << sz) << dbl;
         assign cap_mask[i] = 7'(cap - 8'h01);
      end
   endgenerate

   // ==========================================================================
   // Bus decode: every access answers on the second cycle
   assign req             = avs.read | avs.write;
   assign take            = req & st.done;
   assign avs_waitrequest = req & ~st.done;
   assign lane0           = avs.byteenable[0];
   assign dp_hit          = (avs.address[7:5] == DATA_PAGE) && (avs.address[1:0] == 2'b00);
   assign dp_ep           = avs.address[4:2];
   assign fw_idx          = {dp_ep, st.fw_ptr[dp_ep]};
   assign sie_idx         = {sie.ep, st.sie_ptr[sie.ep]};
   // Link side is dead while firmware has gated its clock
   assign sie_ok          = sie.valid & st.clk_en & ep_en[sie.ep];
   assign sie_we          = sie_ok & sie.write;
   assign fw_we           = take & avs.write & lane0 & dp_hit & ep_en[dp_ep];

   always_comb
   begin
      logic [7:0] rd;
      logic [7:0] clr;
      logic [7:0] set;
      rd      = RST_REG8;
      clr     = RST_REG8;
      set     = RST_REG8;
      next_st = st;
      next_st.evt = 1'b0;

      // Register read, captured on the first cycle of the access
      case (avs.address)
         OFS_OUT_EN:  rd = st.out_en;
         OFS_IN_EN:   rd = st.in_en;
         OFS_SIZE_LO: rd = st.size_lo & SIZE_LO_MASK;
         OFS_SIZE_HI: rd = st.size_hi;
         OFS_DEPTH:   rd = depth;
         OFS_STATUS:
         begin
            rd[BIT_BUS_IDLE_SLEEP_FLAG]   = st.bus_idle_sleep_flag;
            rd[BIT_RESUME] = st.resume;
            rd[BIT_REMOTE_WAKE_REQUEST]   = st.remote_wake_request;
         end
         OFS_CLKCTL:
         begin
            rd[BIT_CLKEN] = st.clk_en;
            rd[BIT_DEEP]  = st.deep;
         end
         OFS_ACCESS:  rd = st.acc_flag;
         OFS_EP_IE:   rd = st.ep_ie;
         OFS_INTCTL:
         begin
            rd[BIT_GIE]  = st.gie;
            rd[BIT_USBE] = st.usbe;
            rd[BIT_USBF] = st.usbf;
         end
         default:
         begin
            if (dp_hit)
            begin
               rd = mem[fw_idx];
            end
         end
      endcase
      next_st.done = req & ~st.done;
      if (req & ~st.done)
      begin
         next_st.rdata = avs.read ? {24'h000000, rd} : 32'h00000000;
      end

      // Register write, taken at the answering edge only
      if (take & avs.write & lane0)
      begin
         case (avs.address)
            // Reserved bits are stored as written, except SIZE_LO bits 1:0 and DEPTH bits 7:4, which are cleared,
            // and those of STATUS, CLKCTL and INTCTL, which are not stored; firmware keeps them zero
            OFS_OUT_EN:  next_st.out_en  = avs.writedata[7:0];
            OFS_IN_EN:   next_st.in_en   = avs.writedata[7:0];
            OFS_SIZE_LO: next_st.size_lo = avs.writedata[7:0] & SIZE_LO_MASK;
            OFS_SIZE_HI: next_st.size_hi = avs.writedata[7:0];
            // Only the wake-up request is writable here
            OFS_STATUS:
            begin
               if (avs.writedata[BIT_REMOTE_WAKE_REQUEST])
               begin
                  next_st.remote_wake_request = 1'b1;
               end
            end
            OFS_CLKCTL:
            begin
               next_st.clk_en = avs.writedata[BIT_CLKEN];
               next_st.deep   = avs.writedata[BIT_DEEP];
            end
            OFS_ACCESS:  clr = avs.writedata[7:0];
            OFS_EP_IE:   next_st.ep_ie = avs.writedata[7:0];
            OFS_INTCTL:
            begin
               next_st.gie  = avs.writedata[BIT_GIE];
               next_st.usbe = avs.writedata[BIT_USBE];
               if (avs.writedata[BIT_USBF])
               begin
                  next_st.usbf = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // Firmware data port walks its own pointer around the buffer
      if (take & lane0 & dp_hit & ep_en[dp_ep])
      begin
         next_st.fw_ptr[dp_ep] = (st.fw_ptr[dp_ep] + 7'h01) & cap_mask[dp_ep];
      end

      // Link-side buffer access
      if (sie_ok)
      begin
         next_st.sie_ptr[sie.ep] = (st.sie_ptr[sie.ep] + 7'h01) & cap_mask[sie.ep];
         set[sie.ep] = 1'b1;
         if (!sie.write)
         begin
            next_st.sie_rdata = mem[sie_idx];
         end
         if (st.ep_ie[sie.ep])
         begin
            next_st.evt = 1'b1;
         end
      end
      // Hardware set wins over a clear in the same cycle
      next_st.acc_flag = (st.acc_flag & ~clr) | set;

      // Data toggle: reload on enable, flip on each finished packet while the link clock is enabled
      for (int i = 0; i < 8; i++)
      begin
         if (ep_en[i] & ~st.ep_en_q[i])
         begin
            next_st.toggle[i] = st.out_en[BIT_TOGGLE];
         end
         else if (sie.pkt_done && st.clk_en && (sie.ep == 3'(i)))
         begin
            next_st.toggle[i] = ~st.toggle[i];
         end
      end
      next_st.ep_en_q = ep_en;

      // Bus idle timer toward suspend
      if (line_active | st.bus_idle_sleep_flag)
      begin
         next_st.idle_cnt = '0;
      end
      else if (st.idle_cnt != IDLE_CYC)
      begin
         next_st.idle_cnt = st.idle_cnt + 20'h00001;
      end
      if (!st.bus_idle_sleep_flag && (st.idle_cnt == IDLE_CYC))
      begin
         next_st.bus_idle_sleep_flag = 1'b1;
         next_st.evt  = 1'b1;
      end
      if (st.bus_idle_sleep_flag && host_resume && !st.resume)
      begin
         next_st.resume = 1'b1;
         next_st.evt    = 1'b1;
      end
      // Leave once resume signalling ends with the link clock running again
      if (st.bus_idle_sleep_flag && st.resume && st.clk_en && !host_resume)
      begin
         next_st.bus_idle_sleep_flag   = 1'b0;
         next_st.resume = 1'b0;
         next_st.deep   = 1'b0;
      end
      if (bus_reset_det)
      begin
         next_st.evt = 1'b1;
      end

      // Remote wake-up pulse of fixed length, bit clears itself
      if (st.remote_wake_request)
      begin
         if (st.wake_cnt == RWAKE_LEN - 20'h00001)
         begin
            next_st.remote_wake_request     = 1'b0;
            next_st.wake_cnt = '0;
         end
         else
         begin
            next_st.wake_cnt = st.wake_cnt + 20'h00001;
         end
      end

      // Event pulse passes two stages before setting the request flag
      next_st.sync1 = st.evt;
      next_st.sync2 = st.sync1;
      if (st.sync2)
      begin
         next_st.usbf = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // Survives every reset except power-on
   always_ff @(posedge sys_clk or negedge por_n)
   begin
      if (!por_n)
      begin
         depth <= RST_REG8;
      end
      else if (ce && take && avs.write && lane0 && (avs.address == OFS_DEPTH))
      begin
         depth <= avs.writedata[7:0] & DEPTH_MASK;
      end
   end

   // Buffer storage has no reset; contents are unknown until written
   always_ff @(posedge sys_clk)
   begin
      if (ce && fw_we)
      begin
         mem[fw_idx] <= avs.writedata[7:0];
      end
      if (ce && sie_we)
      begin
         mem[sie_idx] <= sie.wdata;
      end
   end

   // ==========================================================================
   // Outputs
   assign avs_readdata      = st.rdata;
   assign sie_rdata         = st.sie_rdata;
   assign ep_buf_enable     = st.ep_en_q;
   assign ep_toggle         = st.toggle;
   assign link_clk_en       = st.clk_en;
   assign deep_low_power    = st.deep;
   assign remote_wake_drive = st.remote_wake_request;
   assign usb_irq           = st.usbf & st.usbe & st.gie;

   // ==========================================================================
   // Assertions
   property p_bus_idle_sleep_flag_entry;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && !st.bus_idle_sleep_flag && st.idle_cnt == IDLE_CYC) |=> (st.bus_idle_sleep_flag && st.evt);
   endproperty
   a_bus_idle_sleep_flag_entry: assert property (p_bus_idle_sleep_flag_entry) else $error("suspend not entered");

   property p_resume_flag;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && st.bus_idle_sleep_flag && host_resume && !st.resume) |=> (st.resume && st.evt);
   endproperty
   a_resume_flag: assert property (p_resume_flag) else $error("resume not flagged");

   property p_leave_clears;
      @(posedge sys_clk) disable iff (!resetn)
      $fell(st.bus_idle_sleep_flag) |-> (!st.resume && !st.deep);
   endproperty
   a_leave_clears: assert property (p_leave_clears) else $error("leave kept flags");

   property p_size_lo_zero;
      @(posedge sys_clk) disable iff (!resetn)
      (take && avs.read && avs.address == OFS_SIZE_LO) |-> (avs_readdata[1:0] == 2'b00);
   endproperty
   a_size_lo_zero: assert property (p_size_lo_zero) else $error("size low bits nonzero");

   property p_irq_gate;
      @(posedge sys_clk) disable iff (!resetn)
      usb_irq |-> (st.usbf && st.usbe && st.gie);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

   property p_evt_sync;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && st.evt) ##1 ce ##1 ce |=> st.usbf;
   endproperty
   a_evt_sync: assert property (p_evt_sync) else $error("request flag not set");

   property p_access_irq;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && sie_ok && st.ep_ie[sie.ep]) |=> (st.evt && st.acc_flag[$past(sie.ep)]);
   endproperty
   a_access_irq: assert property (p_access_irq) else $error("access event lost");

   property p_rwake;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && take && avs.write && lane0 && avs.address == OFS_STATUS
       && avs.writedata[BIT_REMOTE_WAKE_REQUEST]) |=> remote_wake_drive;
   endproperty
   a_rwake: assert property (p_rwake) else $error("no wake-up pulse");

   property p_flags_ro;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && st.bus_idle_sleep_flag && !host_resume && !(st.resume && st.clk_en)) |=> st.bus_idle_sleep_flag;
   endproperty
   a_flags_ro: assert property (p_flags_ro) else $error("suspend flag dropped");

   property p_answer;
      @(posedge sys_clk) disable iff (!resetn)
      (ce && req && avs_waitrequest) |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");

endmodule : ueb_endpoint

// [ueb_host_model.sv]
// Host-side partner model: bus activity, resume signalling, bus reset and link strobes
`timescale 1ns/1ps

module ueb_host_model
#(
   parameter int RESUME_LEN = 20
)(
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  bus_quiet,
   input  wire logic                  resume_now,
   input  wire logic                  reset_now,
   input  wire logic                  remote_wake_drive,
   input  wire ueb_pkg::ueb_sie_req_s sie_cmd,
   output logic                       line_active,
   output logic                       host_resume,
   output logic                       bus_reset_det,
   output ueb_pkg::ueb_sie_req_s      sie
);
   import ueb_pkg::*;

   // ==========================================================================
   // Resume signalling
   int   res_cnt;
   logic wake_q;

   // Host answers the end of a wake-up pulse with resume signalling
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         res_cnt <= 0;
         wake_q  <= 1'b0;
      end
      else
      begin
         wake_q <= remote_wake_drive;
         if (resume_now || (wake_q && !remote_wake_drive))
            res_cnt <= RESUME_LEN;
         else if (res_cnt != 0)
            res_cnt <= res_cnt - 1;
      end
   end

   // Resume signalling is bus activity too
   assign host_resume   = (res_cnt != 0);
   assign line_active   = !bus_quiet || host_resume;
   assign bus_reset_det = reset_now;
   assign sie           = sie_cmd;
endmodule : ueb_host_model

// [test_usb_endpoint_buffer_and_suspend.sv]
// Self-checking testbench for the endpoint buffer and suspend block
`timescale 1ns/1ps

module test_usb_endpoint_buffer_and_suspend;
   import ueb_pkg::*;

   // ==========================================================================
   // Signals
   logic         sys_clk, resetn, por_n, ce;
   ueb_avs_req_s avs;
   ueb_sie_req_s sie_cmd, sie;
   logic         avs_waitrequest, line_active, host_resume, bus_reset_det;
   logic [31:0]  avs_readdata;
   logic [7:0]   sie_rdata, ep_buf_enable, ep_toggle;
   logic         link_clk_en, deep_low_power, remote_wake_drive, usb_irq;
   logic         bus_quiet, resume_now, reset_now;
   int           n_mismatch, samples_checked;

   ueb_endpoint #(.IDLE_CYC(20'd20), .RWAKE_LEN(20'd8)) uut (
      .sys_clk(sys_clk), .resetn(resetn), .por_n(por_n), .ce(ce), .avs(avs),
      .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
      .line_active(line_active), .host_resume(host_resume),
      .bus_reset_det(bus_reset_det), .sie(sie), .sie_rdata(sie_rdata),
      .ep_buf_enable(ep_buf_enable), .ep_toggle(ep_toggle), .link_clk_en(link_clk_en),
      .deep_low_power(deep_low_power), .remote_wake_drive(remote_wake_drive),
      .usb_irq(usb_irq));

   ueb_host_model host (
      .sys_clk(sys_clk), .resetn(resetn), .bus_quiet(bus_quiet),
      .resume_now(resume_now), .reset_now(reset_now),
      .remote_wake_drive(remote_wake_drive), .sie_cmd(sie_cmd),
      .line_active(line_active), .host_resume(host_resume),
      .bus_reset_det(bus_reset_det), .sie(sie));

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ==========================================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Request held until waitrequest is seen low, then released
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      avs.read <= !w;
      avs.write <= w;
      avs.address <= a;
      avs.writedata <= {24'h000000, d};
      avs.byteenable <= 4'hf;
      // Answer taken at a rising edge only; a hang is left to the watchdog
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge sys_clk);
      end
      q = avs_readdata[7:0];
      avs.read <= 1'b0;
      avs.write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check({24'h000000, q}, {24'h000000, e});
   endtask : rd_chk

   task automatic link(input logic w, input logic done, input logic [2:0] ep);
      sie_cmd <= '{!done, w, done, ep, 8'h5a};
      @(posedge sys_clk);
      sie_cmd <= '0;
      repeat (6) @(posedge sys_clk);
   endtask : link

   // ==========================================================================
   // Scenarios
   task automatic t_regs;
      for (int a = 0; a < 40; a += 4)
         rd_chk(8'(a), 8'h00);
      wr(OFS_SIZE_LO, 8'hff);
      rd_chk(OFS_SIZE_LO, 8'hfc);
      wr(8'h30, 8'h77);
      rd_chk(8'h30, 8'h00);
      wr(OFS_DEPTH, 8'h05);
      wr(OFS_OUT_EN, 8'h10);
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      rd_chk(OFS_DEPTH, 8'h05);
      rd_chk(OFS_OUT_EN, 8'h00);
      rd_chk(OFS_SIZE_LO, 8'h00);
      por_n <= 1'b0;
      @(posedge sys_clk);
      por_n <= 1'b1;
      @(posedge sys_clk);
      rd_chk(OFS_DEPTH, 8'h00);
   endtask : t_regs

   task automatic t_enable;
      wr(OFS_OUT_EN, 8'h01);
      wr(OFS_OUT_EN, 8'hf3);
      wr(OFS_IN_EN, 8'h0c);
      // Link side is dead until its clock gate is opened
      wr(OFS_CLKCTL, 8'h01);
      check(ep_buf_enable, 8'hff);
      check(ep_toggle & 8'hf2, 8'hf2);
      link(1'b0, 1'b1, 3'd1);
      check(ep_toggle[1], 1'b0);
      // Frozen clock enable must swallow a packet end
      ce <= 1'b0;
      link(1'b0, 1'b1, 3'd1);
      ce <= 1'b1;
      check(ep_toggle[1], 1'b0);
   endtask : t_enable

   task automatic t_data;
      for (int i = 0; i < 9; i++)
         wr(8'h44, 8'ha0 + 8'(i));
      for (int i = 1; i < 9; i++)
         rd_chk(8'h44, 8'ha0 + 8'(i));
      wr(OFS_DEPTH, 8'h01);
      for (int i = 0; i < 17; i++)
         wr(8'h48, 8'h30 + 8'(i));
      rd_chk(8'h48, 8'h31);
      wr(OFS_CLKCTL, 8'h01);
      wr(OFS_EP_IE, 8'h02);
      wr(OFS_INTCTL, 8'h03);
      link(1'b0, 1'b0, 3'd1);
      check(sie_rdata, 8'ha8);
      rd_chk(OFS_ACCESS, 8'h02);
      check(usb_irq, 1'b1);
      rd_chk(OFS_INTCTL, 8'h07);
      wr(OFS_ACCESS, 8'h02);
      wr(OFS_INTCTL, 8'h07);
      rd_chk(OFS_ACCESS, 8'h00);
      check(usb_irq, 1'b0);
      wr(OFS_INTCTL, 8'h02);
      link(1'b0, 1'b0, 3'd1);
      check(usb_irq, 1'b0);
      rd_chk(OFS_INTCTL, 8'h06);
      wr(OFS_EP_IE, 8'h00);
      wr(OFS_ACCESS, 8'h02);
      wr(OFS_INTCTL, 8'h07);
      link(1'b0, 1'b0, 3'd1);
      rd_chk(OFS_ACCESS, 8'h02);
      check(usb_irq, 1'b0);
      link(1'b1, 1'b0, 3'd1);
      rd_chk(8'h44, 8'ha1);
      rd_chk(8'h44, 8'ha2);
      rd_chk(8'h44, 8'h5a);
      reset_now <= 1'b1;
      @(posedge sys_clk);
      reset_now <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check(usb_irq, 1'b1);
      wr(OFS_INTCTL, 8'h07);
   endtask : t_data

   task automatic t_suspend;
      check(usb_irq, 1'b0);
      bus_quiet <= 1'b1;
      repeat (30) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 8'h01);
      check(usb_irq, 1'b1);
      wr(OFS_STATUS, 8'h02);
      rd_chk(OFS_STATUS, 8'h01);
      wr(OFS_CLKCTL, 8'h02);
      check(deep_low_power, 1'b1);
      check(link_clk_en, 1'b0);
      wr(OFS_INTCTL, 8'h07);
      check(usb_irq, 1'b0);
      resume_now <= 1'b1;
      bus_quiet <= 1'b0;
      @(posedge sys_clk);
      resume_now <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd_chk(OFS_STATUS, 8'h03);
      check(usb_irq, 1'b1);
      wr(OFS_CLKCTL, 8'h03);
      repeat (40) @(posedge sys_clk);
      check(deep_low_power, 1'b0);
      rd_chk(OFS_STATUS, 8'h00);
   endtask : t_suspend

   task automatic t_wake;
      wr(OFS_STATUS, 8'h04);
      check(remote_wake_drive, 1'b1);
      repeat (10) @(posedge sys_clk);
      check(remote_wake_drive, 1'b0);
      check(host_resume, 1'b1);
      rd_chk(OFS_STATUS, 8'h00);
   endtask : t_wake

   task automatic summarize;
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   // ==========================================================================
   // Main sequence and watchdog
   initial
   begin
      n_mismatch = 0;
      samples_checked = 0;
      resetn = 1'b0;
      por_n = 1'b0;
      ce = 1'b1;
      avs = '0;
      sie_cmd = '0;
      bus_quiet = 1'b0;
      resume_now = 1'b0;
      reset_now = 1'b0;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_enable();
      t_data();
      t_suspend();
      t_wake();
      summarize();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      summarize();
   end
endmodule : test_usb_endpoint_buffer_and_suspend
